// file: design/dce_pkg.sv
// Package of constants and types for the debug command engine.
`default_nettype none
package dce_pkg;
  localparam logic [7:0] OP_WR_CTL = 8'h04;
  localparam logic [7:0] OP_RD_CTL = 8'h05;
  localparam logic [7:0] OP_RD_REG = 8'h09;
  localparam logic [7:0] OP_WR_PROG = 8'h0a;
  localparam logic [7:0] OP_RD_PROG = 8'h0b;
  localparam logic [7:0] OP_WR_DATA = 8'h0c;
  localparam logic [7:0] OP_RD_DATA = 8'h0d;
  localparam logic [7:0] OP_CRC = 8'h0e;
  localparam logic [7:0] OP_STEP = 8'h10;
  localparam logic [7:0] OP_STUFF = 8'h11;
  localparam logic [7:0] OP_EXEC = 8'h12;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] ACK_BYTE = 8'hff;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int CTL_HALT_BIT = 7;
  localparam int CTL_ALLOW_BIT = 6;
  localparam int CTL_NOTIFY_BIT = 5;
  localparam int CTL_SPIN_BIT = 4;
  localparam int CTL_SRST_BIT = 0;
  localparam logic [7:0] CTL_RSVD_MASK = 8'h0e;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_BLOCKED = 16'hffff;
  localparam int PROG_BYTES = 65536;
  localparam logic [16:0] SIZE_ZERO_LONG = 17'h10000;
  localparam logic [16:0] SIZE_ZERO_SHORT = 17'h00100;

  typedef enum logic [3:0] {
    ST_OPCODE = 4'h0,
    ST_ARG = 4'h1,
    ST_XFER = 4'h2,
    ST_CRC = 4'h3,
    ST_CRC_HI = 4'h4,
    ST_CRC_LO = 4'h5,
    ST_CPU = 4'h6,
    ST_CTL_RD = 4'h7
  } dce_state_type;

  typedef enum logic [1:0] {
    SP_REG = 2'h0,
    SP_PROG = 2'h1,
    SP_DATA = 2'h2
  } dce_space_type;
endpackage : dce_pkg
`default_nettype wire

// file: design/dce_skid_if.sv
// Valid/ready carrier between the engine and its reply buffer.
`default_nettype none
interface dce_skid_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : dce_skid_if
`default_nettype wire

// file: design/dce_skid_buf.sv
// Two-entry reply buffer between the engine and the host byte port.
`default_nettype none
module dce_skid_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  dce_skid_if.dst in_if,
  // Draining side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign in_if.ready = (count_ff != 2'h2);
  assign push = in_if.valid && in_if.ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_if.data[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop)
      begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : dce_skid_buf
`default_nettype wire

// file: design/dce_engine.sv
// Debug command engine: byte command decoder, memory access and CPU control.
`default_nettype none
module dce_engine #(
  parameter int PROG_SIZE = dce_pkg::PROG_BYTES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Command bytes from the host link.
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // Reply bytes to the host link.
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  // Device straps and status.
  input wire logic read_protection_active,
  input wire logic flash_unlocked,
  input wire logic dev_reset_done,
  // Memory access.
  output logic mem_req_ff,
  output logic mem_we_ff,
  output logic [1:0] mem_space_ff,
  output logic [15:0] mem_addr_ff,
  output logic [7:0] mem_wdata_ff,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // CPU control.
  input wire logic break_decoded,
  input wire logic cpu_done,
  output logic cpu_halt_ff,
  output logic cpu_spin_ff,
  output logic cpu_run_ff,
  output logic cpu_stuff_ff,
  output logic cpu_inst_valid_ff,
  output logic [7:0] cpu_inst_ff,
  output logic dev_reset_ff,
  output logic [7:0] debugger_control_ff
);
  dce_skid_if rsp_if ();
  dce_pkg::dce_state_type state_ff;
  logic [7:0] op_ff;
  logic [2:0] arg_cnt_ff;
  logic [16:0] remain_ff;
  logic [15:0] crc_ff;
  logic [7:0] out_byte_ff;
  logic out_valid_ff;
  logic protected_ff;
  logic meta_ff;
  logic flash_meta_ff;
  logic flash_ok_ff;
  logic mem_wait_ff;
  logic debug_mode;
  logic cmd_take;
  logic rsp_take;
  logic ack_pend_ff;

  dce_skid_buf #(.WIDTH(8)) u_buf (
    .clk(clk),
    .rst(rst),
    .in_if(rsp_if),
    .out_valid(rsp_valid),
    .out_data(rsp_data),
    .out_ready(rsp_ready)
  );

  assign rsp_if.valid = out_valid_ff;
  assign rsp_if.data = out_byte_ff;
  assign rsp_take = out_valid_ff && rsp_if.ready;
  assign debug_mode = debugger_control_ff[dce_pkg::CTL_HALT_BIT];
  assign cmd_take = cmd_valid && cmd_ready;
  // Write data is taken only while bytes remain, so a following opcode is not swallowed.
  assign cmd_ready = (state_ff == dce_pkg::ST_OPCODE || state_ff == dce_pkg::ST_ARG ||
                      (state_ff == dce_pkg::ST_XFER && mem_we_ff && !mem_wait_ff &&
                       remain_ff != 17'h00000) ||
                      (state_ff == dce_pkg::ST_CPU && op_ff == dce_pkg::OP_EXEC &&
                       !cpu_done)) &&
                     !out_valid_ff;

  // Number of opcode-dependent argument bytes after the opcode.
  function automatic logic [2:0] arg_bytes(input logic [7:0] op);
    case (op)
      dce_pkg::OP_WR_CTL, dce_pkg::OP_STUFF: arg_bytes = 3'd1;
      dce_pkg::OP_RD_REG: arg_bytes = 3'd3;
      dce_pkg::OP_WR_PROG, dce_pkg::OP_RD_PROG,
      dce_pkg::OP_WR_DATA, dce_pkg::OP_RD_DATA: arg_bytes = 3'd4;
      default: arg_bytes = 3'd0;
    endcase
  endfunction

  // CRC-CCITT update over one byte, MSB first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      r = r[15] ? ((r << 1) ^ dce_pkg::CRC_POLY) : (r << 1);
    end
    crc_step = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Straps pass two flops; they come from outside the engine's timing.
  always_ff @(posedge clk)
  begin
    meta_ff <= read_protection_active;
    protected_ff <= meta_ff;
    flash_meta_ff <= flash_unlocked;
    flash_ok_ff <= flash_meta_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= dce_pkg::ST_OPCODE;
      op_ff <= 8'h00;
      arg_cnt_ff <= 3'd0;
      remain_ff <= 17'h00000;
      crc_ff <= dce_pkg::CRC_INIT;
      out_valid_ff <= 1'b0;
      out_byte_ff <= 8'h00;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_space_ff <= dce_pkg::SP_REG;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      mem_wait_ff <= 1'b0;
      cpu_inst_valid_ff <= 1'b0;
      cpu_stuff_ff <= 1'b0;
      cpu_inst_ff <= 8'h00;
    end
    else
    begin
      mem_req_ff <= 1'b0;
      cpu_inst_valid_ff <= 1'b0;
      if (rsp_take)
      begin
        out_valid_ff <= 1'b0;
      end
      case (state_ff)
        dce_pkg::ST_OPCODE:
        begin
          if (cmd_take)
          begin
            op_ff <= cmd_data;
            arg_cnt_ff <= 3'd0;
            cpu_stuff_ff <= (cmd_data == dce_pkg::OP_STUFF);
            if (arg_bytes(cmd_data) != 3'd0)
            begin
              state_ff <= dce_pkg::ST_ARG;
            end
            else if (cmd_data == dce_pkg::OP_RD_CTL)
            begin
              state_ff <= dce_pkg::ST_CTL_RD;
            end
            else if (cmd_data == dce_pkg::OP_CRC)
            begin
              mem_addr_ff <= 16'h0000;
              mem_space_ff <= dce_pkg::SP_PROG;
              mem_we_ff <= 1'b0;
              remain_ff <= 17'(PROG_SIZE);
              crc_ff <= dce_pkg::CRC_INIT;
              state_ff <= debug_mode ? dce_pkg::ST_CRC : dce_pkg::ST_CRC_HI;
              if (!debug_mode)
              begin
                crc_ff <= dce_pkg::CRC_BLOCKED;
              end
            end
            else if ((cmd_data == dce_pkg::OP_STEP || cmd_data == dce_pkg::OP_EXEC) &&
                     debug_mode && !protected_ff)
            begin
              state_ff <= dce_pkg::ST_CPU;
            end
            // Other opcodes fall through with no effect.
          end
        end
        dce_pkg::ST_ARG:
        begin
          if (cmd_take)
          begin
            arg_cnt_ff <= arg_cnt_ff + 3'd1;
            if (op_ff == dce_pkg::OP_RD_REG)
            begin
              case (arg_cnt_ff)
                3'd0: mem_addr_ff[15:8] <= {4'h0, cmd_data[3:0]};
                3'd1: mem_addr_ff[7:0] <= cmd_data;
                default: remain_ff <= (cmd_data == 8'h00) ? dce_pkg::SIZE_ZERO_SHORT :
                                      {9'h000, cmd_data};
              endcase
            end
            else
            begin
              case (arg_cnt_ff)
                3'd0: mem_addr_ff[15:8] <= cmd_data;
                3'd1: mem_addr_ff[7:0] <= cmd_data;
                3'd2: remain_ff[15:8] <= cmd_data;
                default: remain_ff <= ({remain_ff[15:8], cmd_data} == 16'h0000) ?
                                      dce_pkg::SIZE_ZERO_LONG :
                                      {1'b0, remain_ff[15:8], cmd_data};
              endcase
            end
            mem_we_ff <= (op_ff == dce_pkg::OP_WR_PROG || op_ff == dce_pkg::OP_WR_DATA);
            mem_space_ff <= (op_ff == dce_pkg::OP_RD_REG) ? dce_pkg::SP_REG :
                            (op_ff == dce_pkg::OP_WR_DATA || op_ff == dce_pkg::OP_RD_DATA) ?
                            dce_pkg::SP_DATA : dce_pkg::SP_PROG;
            if (arg_cnt_ff + 3'd1 == arg_bytes(op_ff))
            begin
              state_ff <= dce_pkg::ST_XFER;
              if (op_ff == dce_pkg::OP_STUFF)
              begin
                cpu_inst_ff <= cmd_data;
                state_ff <= (debug_mode && !protected_ff) ? dce_pkg::ST_CPU :
                            dce_pkg::ST_OPCODE;
              end
              else if (op_ff == dce_pkg::OP_WR_CTL)
              begin
                state_ff <= dce_pkg::ST_OPCODE;
              end
            end
          end
        end
        dce_pkg::ST_XFER:
        begin
          // A write still in flight must be acknowledged before the next command.
          if (remain_ff == 17'h00000 && !mem_wait_ff)
          begin
            state_ff <= dce_pkg::ST_OPCODE;
          end
          else if (mem_we_ff)
          begin
            if (mem_wait_ff && mem_ack)
            begin
              mem_wait_ff <= 1'b0;
              mem_addr_ff <= mem_addr_ff + 16'h0001;
            end
            else if (cmd_take)
            begin
              remain_ff <= remain_ff - 17'h00001;
              // Blocked writes are consumed from the link and dropped.
              if (debug_mode && !protected_ff &&
                  (mem_space_ff != dce_pkg::SP_PROG || flash_ok_ff))
              begin
                mem_req_ff <= 1'b1;
                mem_wdata_ff <= cmd_data;
                mem_wait_ff <= 1'b1;
              end
              else
              begin
                mem_addr_ff <= mem_addr_ff + 16'h0001;
              end
            end
          end
          else if (!out_valid_ff || rsp_take)
          begin
            if (!debug_mode || (protected_ff && mem_space_ff != dce_pkg::SP_DATA))
            begin
              out_byte_ff <= dce_pkg::FILL_BYTE;
              out_valid_ff <= 1'b1;
              remain_ff <= remain_ff - 17'h00001;
            end
            else if (!mem_wait_ff)
            begin
              mem_req_ff <= 1'b1;
              mem_wait_ff <= 1'b1;
            end
            else if (mem_ack)
            begin
              mem_wait_ff <= 1'b0;
              out_byte_ff <= mem_rdata;
              out_valid_ff <= 1'b1;
              remain_ff <= remain_ff - 17'h00001;
              mem_addr_ff <= mem_addr_ff + 16'h0001;
            end
          end
        end
        dce_pkg::ST_CRC:
        begin
          // One byte per fetch, so the reply lags by at least two cycles per byte plus the memory latency.
          if (remain_ff == 17'h00000)
          begin
            state_ff <= dce_pkg::ST_CRC_HI;
          end
          else if (!mem_wait_ff)
          begin
            mem_req_ff <= 1'b1;
            mem_wait_ff <= 1'b1;
          end
          else if (mem_ack)
          begin
            mem_wait_ff <= 1'b0;
            crc_ff <= crc_step(crc_ff, mem_rdata);
            remain_ff <= remain_ff - 17'h00001;
            mem_addr_ff <= mem_addr_ff + 16'h0001;
          end
        end
        dce_pkg::ST_CRC_HI, dce_pkg::ST_CRC_LO, dce_pkg::ST_CTL_RD:
        begin
          if (!out_valid_ff || rsp_take)
          begin
            out_valid_ff <= 1'b1;
            state_ff <= (state_ff == dce_pkg::ST_CRC_HI) ? dce_pkg::ST_CRC_LO :
                        dce_pkg::ST_OPCODE;
            out_byte_ff <= (state_ff == dce_pkg::ST_CRC_HI) ? crc_ff[15:8] :
                           (state_ff == dce_pkg::ST_CRC_LO) ? crc_ff[7:0] :
                           debugger_control_ff;
          end
        end
        dce_pkg::ST_CPU:
        begin
          // Execute bytes stream to the CPU until it reports completion.
          if (op_ff == dce_pkg::OP_EXEC && cmd_take)
          begin
            cpu_inst_ff <= cmd_data;
            cpu_inst_valid_ff <= 1'b1;
          end
          if (cpu_done)
          begin
            state_ff <= dce_pkg::ST_OPCODE;
          end
        end
        default: state_ff <= dce_pkg::ST_OPCODE;
      endcase
      if (ack_pend_ff && !out_valid_ff && state_ff == dce_pkg::ST_OPCODE)
      begin
        out_byte_ff <= dce_pkg::ACK_BYTE;
        out_valid_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, halt and reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      debugger_control_ff <= dce_pkg::CTL_RESET;
      dev_reset_ff <= 1'b0;
      ack_pend_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == dce_pkg::ST_ARG && cmd_take && op_ff == dce_pkg::OP_WR_CTL)
      begin
        // Reserved bits are kept zero whatever the host sends.
        debugger_control_ff <= cmd_data & ~dce_pkg::CTL_RSVD_MASK;
        if (protected_ff && debug_mode)
        begin
          debugger_control_ff[dce_pkg::CTL_HALT_BIT] <= 1'b1;
        end
        dev_reset_ff <= cmd_data[dce_pkg::CTL_SRST_BIT];
      end
      else if (dev_reset_ff && dev_reset_done)
      begin
        dev_reset_ff <= 1'b0;
        debugger_control_ff[dce_pkg::CTL_SRST_BIT] <= 1'b0;
      end
      // Break handling; set wins over any concurrent write.
      if (break_decoded && debugger_control_ff[dce_pkg::CTL_ALLOW_BIT] &&
          !debugger_control_ff[dce_pkg::CTL_SPIN_BIT])
      begin
        debugger_control_ff[dce_pkg::CTL_HALT_BIT] <= 1'b1;
      end
      if (break_decoded && debugger_control_ff[dce_pkg::CTL_ALLOW_BIT] &&
          debugger_control_ff[dce_pkg::CTL_NOTIFY_BIT])
      begin
        ack_pend_ff <= 1'b1;
      end
      else if (ack_pend_ff && !out_valid_ff && state_ff == dce_pkg::ST_OPCODE)
      begin
        ack_pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpu_halt_ff <= 1'b0;
      cpu_spin_ff <= 1'b0;
      cpu_run_ff <= 1'b0;
    end
    else
    begin
      cpu_halt_ff <= debug_mode;
      cpu_spin_ff <= debugger_control_ff[dce_pkg::CTL_ALLOW_BIT] &&
                     debugger_control_ff[dce_pkg::CTL_SPIN_BIT];
      cpu_run_ff <= (state_ff == dce_pkg::ST_CPU) && !cpu_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_crc_blocked: assert property (@(posedge clk) disable iff (rst)
    (state_ff == dce_pkg::ST_OPCODE && cmd_take && cmd_data == dce_pkg::OP_CRC && !debug_mode)
    |=> crc_ff == dce_pkg::CRC_BLOCKED)
    else $error("crc not forced outside debug mode");
  a_cpu_ignored: assert property (@(posedge clk) disable iff (rst)
    (state_ff == dce_pkg::ST_OPCODE && cmd_take &&
     (cmd_data == dce_pkg::OP_STEP || cmd_data == dce_pkg::OP_EXEC) &&
     (!debug_mode || protected_ff)) |=> state_ff != dce_pkg::ST_CPU)
    else $error("step or execute accepted while blocked");
  a_halt_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 cpu_halt_ff == $past(debug_mode))
    else $error("halt output does not track flag");
  a_no_write_blocked: assert property (@(posedge clk) disable iff (rst)
    mem_req_ff && mem_we_ff |-> $past(debug_mode) && !$past(protected_ff))
    else $error("memory write while blocked");
  a_prog_flash: assert property (@(posedge clk) disable iff (rst)
    mem_req_ff && mem_we_ff && mem_space_ff == dce_pkg::SP_PROG |-> $past(flash_ok_ff))
    else $error("program write while flash locked");
  a_break_halt: assert property (@(posedge clk) disable iff (rst)
    break_decoded && debugger_control_ff[dce_pkg::CTL_ALLOW_BIT] &&
    !debugger_control_ff[dce_pkg::CTL_SPIN_BIT] |=> debug_mode)
    else $error("break did not halt");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    (debugger_control_ff & dce_pkg::CTL_RSVD_MASK) == 8'h00)
    else $error("reserved control bits set");
  a_fill_read: assert property (@(posedge clk) disable iff (rst)
    state_ff == dce_pkg::ST_XFER && !mem_we_ff && !debug_mode && remain_ff != 17'h00000 &&
    !out_valid_ff |=> out_valid_ff && out_byte_ff == dce_pkg::FILL_BYTE)
    else $error("blocked read not filled");
endmodule : dce_engine
`default_nettype wire

// file: tb/dce_mem_model.sv
// Memory, CPU and reset-controller responder on the far side of the engine.
`default_nettype none
module dce_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Memory port.
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // CPU and device reset.
  input wire logic cpu_run,
  output logic cpu_done,
  input wire logic dev_reset,
  output logic dev_reset_done,
  // Counters for the bench.
  output int writes,
  output int runs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;
  logic [15:0] addr_ff;
  logic run_d;
  ////////////////////////////////////////////////////////////////////////////
  // Answers two cycles late so that the engine never relies on a fixed latency.
  always_ff @(posedge clk)
  begin
    mem_ack <= 1'b0;
    dev_reset_done <= dev_reset;
    run_d <= cpu_run;
    cpu_done <= cpu_run && run_d && !cpu_done;
    if (rst)
    begin
      wait_ff <= 2'd0;
      writes <= 0;
      runs <= 0;
      mem_rdata <= 8'h00;
    end
    else
    begin
      if (mem_req)
      begin
        wait_ff <= 2'd2;
        addr_ff <= mem_addr;
        if (mem_we) writes <= writes + 1;
      end
      else if (wait_ff != 2'd0)
      begin
        wait_ff <= wait_ff - 2'd1;
        mem_ack <= (wait_ff == 2'd1);
        mem_rdata <= addr_ff[7:0] ^ 8'h5a;
      end
      else
        mem_rdata <= ~mem_rdata;
      if (cpu_run && !run_d) runs <= runs + 1;
    end
  end
endmodule // dce_mem_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench driving the engine's command and reply byte streams.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic rsp_ready = 1'b0;
  logic read_protection_active = 1'b0;
  logic flash_unlocked = 1'b0;
  logic break_decoded = 1'b0;
  logic cmd_ready, rsp_valid, mem_req, mem_we, mem_ack, cpu_done, cpu_halt, cpu_spin;
  logic cpu_run, dev_reset, dev_reset_done;
  logic [7:0] rsp_data, mem_rdata, ctl, rx, inst, wdata;
  logic [15:0] mem_addr;
  int writes, runs, w0, r0;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  dce_engine #(.PROG_SIZE(16)) dut_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ready(rsp_ready), .read_protection_active(read_protection_active),
    .flash_unlocked(flash_unlocked), .dev_reset_done(dev_reset_done), .mem_req_ff(mem_req),
    .mem_we_ff(mem_we), .mem_space_ff(), .mem_addr_ff(mem_addr), .mem_wdata_ff(wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .break_decoded(break_decoded),
    .cpu_done(cpu_done), .cpu_halt_ff(cpu_halt), .cpu_spin_ff(cpu_spin), .cpu_run_ff(cpu_run),
    .cpu_stuff_ff(), .cpu_inst_valid_ff(), .cpu_inst_ff(inst), .dev_reset_ff(dev_reset),
    .debugger_control_ff(ctl));
  dce_mem_model model_u (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .cpu_run(cpu_run),
    .cpu_done(cpu_done), .dev_reset(dev_reset), .dev_reset_done(dev_reset_done),
    .writes(writes), .runs(runs));
  ////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Checks: %0d, mismatches: %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are judged at the falling edge, where the combinational ready has settled.
  task automatic send(input logic [7:0] b);
    cmd_valid <= 1'b1;
    cmd_data <= b;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic recv(input logic [7:0] exp);
    rsp_ready <= 1'b1;
    @(negedge clk);
    while (rsp_valid !== 1'b1) @(negedge clk);
    rx = rsp_data;
    @(posedge clk);
    chk(rx, exp);
  endtask
  task automatic cmd(input logic [47:0] b, input int n);
    for (int i = 0; i < n; i++) send(b[47-8*i -: 8]);
    cmd_valid <= 1'b0;
  endtask
  // The reply side stalls eight cycles first, so the buffer must hold the bytes.
  task automatic xfer(input logic [47:0] b, input int n, input logic [15:0] e, input int k);
    cmd(b, n);
    repeat (8) @(posedge clk);
    if (k == 0)
      chk({7'h00, rsp_valid}, 8'h00);
    else
    begin
      if (k == 2) recv(e[15:8]);
      recv(e[7:0]);
      rsp_ready <= 1'b0;
    end
  endtask
  task automatic wr_ctl(input logic [7:0] v);
    cmd({8'h04, v, 32'h0}, 2);
    repeat (6) @(posedge clk);
  endtask
  task automatic break_opcode();
    break_decoded <= 1'b1;
    @(posedge clk);
    break_decoded <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int a = 0; a < n; a++)
    begin
      c = c ^ {a[7:0] ^ 8'h5a, 8'h00};
      for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ctl, 8'h00);
    w0 = writes;
    r0 = runs;
    xfer({8'h0d, 40'h0003000200}, 5, 16'hffff, 2);
    xfer({8'h0b, 40'h0003000100}, 5, 16'h00ff, 1);
    xfer({8'h0e, 40'h0}, 1, 16'hffff, 2);
    xfer({8'h0c, 40'h00010001a5}, 6, 16'h0, 0);
    xfer({8'h10, 40'h0}, 1, 16'h0, 0);
    xfer({8'h0f, 40'h0}, 1, 16'h0, 0);
    chk(8'(writes - w0), 8'h00);
    chk(8'(runs - r0), 8'h00);
    wr_ctl(8'h81);
    xfer({8'h05, 40'h0}, 1, 16'h0080, 1);
    chk({7'h00, cpu_halt}, 8'h01);
    xfer({8'h0d, 40'h0003000200}, 5, 16'h595e, 2);
    xfer({8'h09, 40'h0007010000}, 4, 16'h005d, 1);
    xfer({8'h0b, 40'h0020000100}, 5, 16'h007a, 1);
    w0 = writes;
    xfer({8'h0a, 40'h0001000133}, 6, 16'h0, 0);
    chk(8'(writes - w0), 8'h00);
    flash_unlocked <= 1'b1;
    repeat (4) @(posedge clk);
    xfer({8'h0a, 40'h0001000133}, 6, 16'h0, 0);
    chk(8'(writes - w0), 8'h01);
    chk(wdata, 8'h33);
    xfer({8'h0e, 40'h0}, 1, crc_of(16), 2);
    r0 = runs;
    xfer({8'h10, 40'h0}, 1, 16'h0, 0);
    xfer({8'h11, 40'h9f00000000}, 2, 16'h0, 0);
    xfer({8'h12, 40'h3c00000000}, 2, 16'h0, 0);
    chk(inst, 8'h3c);
    chk(8'(runs - r0), 8'h03);
    wr_ctl(8'h60);
    break_opcode();
    recv(8'hff);
    rsp_ready <= 1'b0;
    xfer({8'h05, 40'h0}, 1, 16'h00e0, 1);
    wr_ctl(8'h50);
    break_opcode();
    chk({6'h00, cpu_spin, cpu_halt}, 8'h02);
    wr_ctl(8'h00);
    break_opcode();
    chk({7'h00, cpu_halt}, 8'h00);
    wr_ctl(8'h80);
    read_protection_active <= 1'b1;
    repeat (4) @(posedge clk);
    wr_ctl(8'h00);
    xfer({8'h05, 40'h0}, 1, 16'h0080, 1);
    xfer({8'h0d, 40'h0003000100}, 5, 16'h0059, 1);
    xfer({8'h0b, 40'h0003000100}, 5, 16'h00ff, 1);
    r0 = runs;
    xfer({8'h10, 40'h0}, 1, 16'h0, 0);
    chk(8'(runs - r0), 8'h00);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
